// *** rtl/dsba_cfg.svh ***
// Constants for the data space byte/word access block
`ifndef DSBA_CFG_SVH
`define DSBA_CFG_SVH
`define DSBA_DATA_W        16
`define DSBA_ADDR_W        16
`define DSBA_WREG_N        16
`define DSBA_WREG_IDX_W    4
`define DSBA_MEM_WORDS     512
`define DSBA_MEM_IDX_W     9
`define DSBA_STEP_BYTE     16'h0001
`define DSBA_STEP_WORD     16'h0002
`define DSBA_BYTE_SEL_BIT  0
`define DSBA_SIGN_BIT      7
`define DSBA_WREG_RESET    16'h0000
`define DSBA_RDATA_RESET   16'h0000
`endif

// *** rtl/dsba_pkg.sv ***
// Types for the data space byte/word access block
package dsba_pkg;
    typedef enum logic [3:0] {
        DSBA_OP_NONE  = 4'b0001,
        DSBA_OP_LOAD  = 4'b0010,
        DSBA_OP_STORE = 4'b0100,
        DSBA_OP_EXT   = 4'b1000
    } dsba_op_t;
    typedef enum logic [2:0] {
        DSBA_ST_IDLE  = 3'b001,
        DSBA_ST_READ  = 3'b010,
        DSBA_ST_TRAP  = 3'b100
    } dsba_state_t;
endpackage : dsba_pkg

// *** rtl/dsba_lane_mem.sv ***
// Two byte lanes with shared word decode and separate write enables
`timescale 1ns/100ps
`include "dsba_cfg.svh"
module dsba_lane_mem (
    input  wire logic                          sys_clk,
    input  wire logic [`DSBA_MEM_IDX_W-1:0]    wordIdx,
    input  wire logic                          wrLow,
    input  wire logic                          wrHigh,
    input  wire logic [`DSBA_DATA_W-1:0]       wrData,
    output logic      [`DSBA_DATA_W-1:0]       rdData
);
    logic [7:0] laneLow  [0:`DSBA_MEM_WORDS-1];
    logic [7:0] laneHigh [0:`DSBA_MEM_WORDS-1];

    always_ff @(posedge sys_clk)
    begin
        if (wrLow)
        begin
            laneLow[wordIdx] <= wrData[7:0];
        end
        if (wrHigh)
        begin
            laneHigh[wordIdx] <= wrData[15:8];
        end
    end

    // Whole word always read, byte choice made downstream
    always_ff @(posedge sys_clk)
    begin
        rdData <= {laneHigh[wordIdx], laneLow[wordIdx]};
    end
endmodule : dsba_lane_mem

// *** rtl/dsba_access.sv ***
// Load/store access path: address stepping, lane steering, alignment trap, extends
// Functional notes
// - Post-increment advances address by 1 for bytes, 2 for words.
// - Byte read fetches whole word; address bit 0 picks the byte.
// - Selected byte is delivered on low eight data bits.
// - Two byte lanes, shared word decode, byte write enables one lane.
// - Word accesses must be even; odd word access is never valid.
// - Odd word read or write raises an address error trap request.
// - Misaligned read lets the current instruction finish before trapping.
// - Misaligned write executes but suppresses all lane writes.
// - Trap taken after faulting instruction; pointer kept, but a faulting load still writes its destination.
// - Byte load writes register low byte only; high byte kept.
// - Sign extend copies bit 7 into the upper byte.
// - Zero extend clears the upper byte of the register.
`timescale 1ns/100ps
`include "dsba_cfg.svh"
module dsba_access (
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic                          opValid,
    input  wire dsba_pkg::dsba_op_t            opKind,
    input  wire logic                          opByte,
    input  wire logic                          opSigned,
    input  wire logic                          usePostInc,
    input  wire logic [`DSBA_WREG_IDX_W-1:0]   sourceWorkingRegister,
    input  wire logic [`DSBA_WREG_IDX_W-1:0]   destWorkingRegister,
    input  wire logic [`DSBA_DATA_W-1:0]       storeData,
    output logic                               opDone,
    output logic [`DSBA_DATA_W-1:0]            loadData,
    output logic [`DSBA_ADDR_W-1:0]            effectiveAddress,
    output logic                               addrErrTrap,
    output logic                               addrErrIsWrite,
    output logic                               trapVector,
    output logic [`DSBA_DATA_W-1:0]            wregView
);
    ////////////////////////////////////////////////////////////////////////////
    logic [`DSBA_DATA_W-1:0]     wreg [0:`DSBA_WREG_N-1];
    dsba_pkg::dsba_state_t       state;
    logic [`DSBA_ADDR_W-1:0]     addr;
    logic                        byteSel;
    logic                        pendByte;
    logic                        pendTrap;
    logic [`DSBA_WREG_IDX_W-1:0] pendDest;
    logic [`DSBA_DATA_W-1:0]     memRd;
    logic                        misaligned;
    logic                        isAccess;
    logic                        takeOp;
    logic                        memWrLow;
    logic                        memWrHigh;
    logic [`DSBA_DATA_W-1:0]     memWrData;
    logic [`DSBA_DATA_W-1:0]     steered;
    logic [`DSBA_DATA_W-1:0]     next_wreg;
    logic [`DSBA_ADDR_W-1:0]     next_addr;

    ////////////////////////////////////////////////////////////////////////////
    assign takeOp   = opValid && (state == dsba_pkg::DSBA_ST_IDLE);
    assign isAccess = (opKind == dsba_pkg::DSBA_OP_LOAD) || (opKind == dsba_pkg::DSBA_OP_STORE);
    assign addr     = wreg[sourceWorkingRegister];
    // Word at odd address is never a valid access
    assign misaligned = takeOp && isAccess && !opByte
                        && addr[`DSBA_BYTE_SEL_BIT];

    // Step scaled by operand size
    assign next_addr = addr + (opByte ? `DSBA_STEP_BYTE : `DSBA_STEP_WORD);

    // Lane enables; both held off on a misaligned store
    always_comb
    begin
        memWrLow  = 1'b0;
        memWrHigh = 1'b0;
        memWrData = storeData;
        if (takeOp && opKind == dsba_pkg::DSBA_OP_STORE && !misaligned)
        begin
            if (opByte)
            begin
                memWrData = {storeData[7:0], storeData[7:0]};
                memWrLow  = !addr[`DSBA_BYTE_SEL_BIT];
                memWrHigh = addr[`DSBA_BYTE_SEL_BIT];
            end
            else
            begin
                memWrLow  = 1'b1;
                memWrHigh = 1'b1;
            end
        end
    end

    dsba_lane_mem u_mem (
        .sys_clk (sys_clk),
        .wordIdx (addr[`DSBA_MEM_IDX_W:1]),
        .wrLow   (memWrLow),
        .wrHigh  (memWrHigh),
        .wrData  (memWrData),
        .rdData  (memRd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pick byte from fetched word onto the low lane
    always_comb
    begin
        if (pendByte)
        begin
            steered = {8'h00, byteSel ? memRd[15:8] : memRd[7:0]};
        end
        else
        begin
            steered = memRd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state    <= dsba_pkg::DSBA_ST_IDLE;
            pendTrap <= 1'b0;
        end
        else
        begin
            case (state)
                dsba_pkg::DSBA_ST_IDLE:
                begin
                    if (takeOp && opKind == dsba_pkg::DSBA_OP_LOAD)
                    begin
                        state    <= dsba_pkg::DSBA_ST_READ;
                        pendTrap <= misaligned;
                    end
                    else if (misaligned)
                    begin
                        state <= dsba_pkg::DSBA_ST_TRAP;
                    end
                end
                dsba_pkg::DSBA_ST_READ:
                begin
                    // Load completes first, trap follows
                    state <= pendTrap ? dsba_pkg::DSBA_ST_TRAP : dsba_pkg::DSBA_ST_IDLE;
                end
                dsba_pkg::DSBA_ST_TRAP:
                begin
                    state    <= dsba_pkg::DSBA_ST_IDLE;
                    pendTrap <= 1'b0;
                end
                default:
                begin
                    state <= dsba_pkg::DSBA_ST_IDLE;
                end
            endcase
        end
    end

    // Load context captured at take, consumed when the fetched word returns
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            byteSel  <= 1'b0;
            pendByte <= 1'b0;
            pendDest <= '0;
        end
        else if (takeOp && opKind == dsba_pkg::DSBA_OP_LOAD)
        begin
            byteSel  <= addr[`DSBA_BYTE_SEL_BIT];
            pendByte <= opByte;
            pendDest <= destWorkingRegister;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Working register file updates
    always_comb
    begin
        next_wreg = wreg[destWorkingRegister];
        if (opKind == dsba_pkg::DSBA_OP_EXT)
        begin
            if (opSigned)
            begin
                next_wreg[15:8] = {8{next_wreg[`DSBA_SIGN_BIT]}};
            end
            else
            begin
                next_wreg[15:8] = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < `DSBA_WREG_N; i++)
            begin
                wreg[i] <= `DSBA_WREG_RESET;
            end
        end
        else
        begin
            if (takeOp && opKind == dsba_pkg::DSBA_OP_EXT)
            begin
                wreg[destWorkingRegister] <= next_wreg;
            end
            // Faulting access leaves pointer as it stood before the fault
            if (takeOp && isAccess && usePostInc && !misaligned)
            begin
                wreg[sourceWorkingRegister] <= next_addr;
            end
            if (state == dsba_pkg::DSBA_ST_READ)
            begin
                if (pendByte)
                begin
                    wreg[pendDest][7:0] <= steered[7:0];
                end
                else
                begin
                    wreg[pendDest] <= steered;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trap request pulse, one cycle wide by construction
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            addrErrTrap <= 1'b0;
        end
        else
        begin
            addrErrTrap <= misaligned;
        end
    end

    // Direction held until the next fault so a handler can still read it
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            addrErrIsWrite <= 1'b0;
        end
        else if (misaligned)
        begin
            addrErrIsWrite <= (opKind == dsba_pkg::DSBA_OP_STORE);
        end
    end

    // Vector only once the instruction has finished
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            trapVector <= 1'b0;
        end
        else
        begin
            trapVector <= (state == dsba_pkg::DSBA_ST_TRAP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Loads finish one cycle later than stores and extends
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            opDone <= 1'b0;
        end
        else
        begin
            opDone <= (takeOp && opKind != dsba_pkg::DSBA_OP_LOAD)
                      || (state == dsba_pkg::DSBA_ST_READ);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            loadData <= `DSBA_RDATA_RESET;
        end
        else if (state == dsba_pkg::DSBA_ST_READ)
        begin
            loadData <= steered;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            effectiveAddress <= '0;
        end
        else if (takeOp && isAccess)
        begin
            effectiveAddress <= addr;
        end
    end

    // Trails the select by a cycle; cheaper than a second read port
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            wregView <= `DSBA_WREG_RESET;
        end
        else
        begin
            wregView <= wreg[destWorkingRegister];
        end
    end
endmodule : dsba_access

// *** tb/dsba_access_checker.sv ***
// Port assertions for the access block
`timescale 1ns/100ps
module dsba_access_checker (
    input wire logic               sys_clk,
    input wire logic               reset,
    input wire logic               opValid,
    input wire dsba_pkg::dsba_op_t opKind,
    input wire logic               opByte,
    input wire logic               opDone,
    input wire logic [15:0]        loadData,
    input wire logic [15:0]        effectiveAddress,
    input wire logic               addrErrTrap,
    input wire logic               addrErrIsWrite,
    input wire logic               trapVector
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    a_trap_one_pulse: assert property (addrErrTrap |=> !addrErrTrap)
        else $error("trap pulse too long");
    a_trap_word_cause: assert property (addrErrTrap |-> $past(opValid) && !$past(opByte)
        && $past(opKind) inside {dsba_pkg::DSBA_OP_LOAD, dsba_pkg::DSBA_OP_STORE})
        else $error("trap without word access");
    a_trap_rw_flag: assert property (addrErrTrap
        |-> addrErrIsWrite == ($past(opKind) == dsba_pkg::DSBA_OP_STORE))
        else $error("trap direction wrong");
    a_store_trap_done: assert property (addrErrTrap && addrErrIsWrite |-> opDone)
        else $error("faulting store not finished");
    a_store_vector: assert property (addrErrTrap && addrErrIsWrite |=> trapVector)
        else $error("store trap not taken");
    a_load_vector: assert property (addrErrTrap && !addrErrIsWrite |=> opDone ##1 trapVector)
        else $error("load trap order wrong");
    a_vector_cause: assert property (trapVector
        |-> $past(addrErrTrap) && addrErrIsWrite || $past(addrErrTrap, 2) && !addrErrIsWrite)
        else $error("vector without trap");
    a_byte_load_low: assert property (opDone && $past(opValid, 2) && $past(opByte, 2)
        && $past(opKind, 2) == dsba_pkg::DSBA_OP_LOAD |-> loadData[15:8] == 8'h00)
        else $error("byte load upper not clear");
    a_store_even: assert property (opDone && !addrErrTrap && $past(opValid)
        && !$past(opByte) && $past(opKind) == dsba_pkg::DSBA_OP_STORE |-> !effectiveAddress[0])
        else $error("odd word store accepted");
endmodule : dsba_access_checker

bind dsba_access dsba_access_checker i_dsba_access_checker (.sys_clk(sys_clk), .reset(reset),
    .opValid(opValid), .opKind(opKind), .opByte(opByte), .opDone(opDone), .loadData(loadData),
    .effectiveAddress(effectiveAddress), .addrErrTrap(addrErrTrap),
    .addrErrIsWrite(addrErrIsWrite), .trapVector(trapVector));

// *** tb/dsba_model.sv ***
// Model of the byte-laned memory and working registers
`timescale 1ns/100ps
module dsba_model;
    logic [7:0]  lowLane  [512];
    logic [7:0]  highLane [512];
    logic [15:0] wreg     [16] = '{default: 16'h0000};
    logic [15:0] ea;
    logic        bad;
    ////////////////////////////////////////////////////////////
    // One access; returns what a load should deliver
    function automatic logic [15:0] apply(dsba_pkg::dsba_op_t k, logic b, logic s, logic pi,
                                          logic [3:0] src, logic [3:0] dst, logic [15:0] d);
        logic [15:0] rd;
        logic [7:0]  lo;
        logic        st;
        ea = wreg[src];
        st = k == dsba_pkg::DSBA_OP_STORE;
        bad = k != dsba_pkg::DSBA_OP_EXT && !b && ea[0];
        rd = {highLane[ea[9:1]], lowLane[ea[9:1]]};
        if (b)
            rd = {8'h00, 8'(rd >> (ea[0] * 8))};
        lo = wreg[dst][7:0];
        if (k == dsba_pkg::DSBA_OP_EXT)
            wreg[dst] = {s ? {8{lo[7]}} : 8'h00, lo};
        // Faulting load result is left unknown
        if (k == dsba_pkg::DSBA_OP_LOAD)
            wreg[dst] = bad ? 16'hxxxx : b ? {wreg[dst][15:8], rd[7:0]} : rd;
        if (st && !bad && (!b || !ea[0]))
            lowLane[ea[9:1]] = d[7:0];
        if (st && !bad && (!b || ea[0]))
            highLane[ea[9:1]] = b ? d[7:0] : d[15:8];
        if (pi && !bad && k != dsba_pkg::DSBA_OP_EXT)
            wreg[src] = wreg[src] + (b ? 16'h0001 : 16'h0002);
        return rd;
    endfunction : apply
endmodule : dsba_model

// *** tb/testbench.sv ***
// Self-checking bench for the access block
`timescale 1ns/100ps
module testbench;
    localparam dsba_pkg::dsba_op_t opLd = dsba_pkg::DSBA_OP_LOAD;
    localparam dsba_pkg::dsba_op_t opSt = dsba_pkg::DSBA_OP_STORE;
    localparam dsba_pkg::dsba_op_t opEx = dsba_pkg::DSBA_OP_EXT;
    logic               sys_clk, reset, opValid, opByte, opSigned, usePostInc;
    dsba_pkg::dsba_op_t opKind;
    logic [3:0]         srcReg, dstReg;
    logic [15:0]        storeData, loadData, effAddr, wregView;
    logic               opDone, trap, trapIsWr, trapVec;
    int                 errors, checks, trapAt, vecAt, doneAt;
    dsba_model i_dsba_model ();
    dsba_access i_dsba_access (.sys_clk(sys_clk), .reset(reset), .opValid(opValid),
        .opKind(opKind), .opByte(opByte), .opSigned(opSigned), .usePostInc(usePostInc),
        .sourceWorkingRegister(srcReg), .destWorkingRegister(dstReg), .storeData(storeData),
        .opDone(opDone), .loadData(loadData), .effectiveAddress(effAddr), .addrErrTrap(trap),
        .addrErrIsWrite(trapIsWr), .trapVector(trapVec), .wregView(wregView));
    ////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One request, then five cycles of watching the pulses
    task automatic doOp(dsba_pkg::dsba_op_t k, logic b, logic s, logic pi, logic [3:0] src,
                        logic [3:0] dst);
        logic [15:0] exp;
        logic [15:0] d;
        logic        bad;
        d = 16'($urandom);
        exp = i_dsba_model.apply(k, b, s, pi, src, dst, d);
        bad = i_dsba_model.bad;
        @(posedge sys_clk);
        opValid <= 1'b1;
        opKind <= k;
        opByte <= b;
        opSigned <= s;
        usePostInc <= pi;
        srcReg <= src;
        dstReg <= dst;
        storeData <= d;
        @(posedge sys_clk);
        opValid <= 1'b0;
        {trapAt, vecAt, doneAt} = '0;
        for (int c = 1; c < 6; c++)
        begin
            #1;
            doneAt += opDone ? c : 0;
            trapAt += trap ? c : 0;
            vecAt += trapVec ? c : 0;
            @(posedge sys_clk);
        end
        #1;
        check("done", 16'(doneAt), 16'(k == opLd ? 2 : 1));
        check("trap", 16'(trapAt), 16'(bad));
        check("vector", 16'(vecAt), 16'(bad ? (k == opSt ? 2 : 3) : 0));
        if (bad)
            check("isWrite", 16'(trapIsWr), 16'(k == opSt));
        if (k != opEx)
            check("address", effAddr, i_dsba_model.ea);
        if (k == opLd && !bad)
            check("load", loadData, exp);
    endtask : doOp

    task automatic viewReg(logic [3:0] r);
        @(posedge sys_clk);
        dstReg <= r;
        repeat (2) @(posedge sys_clk);
        #1;
        check("wreg", wregView, i_dsba_model.wreg[r]);
    endtask : viewReg

    task automatic final_report();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Whole run is near 390 cycles, well inside the 10000-cycle limit
    initial
    begin
        #200_000;
        errors++;
        final_report();
    end

    initial
    begin
        {opValid, opByte, opSigned, usePostInc, srcReg, dstReg, storeData} = '0;
        opKind = dsba_pkg::DSBA_OP_NONE;
        reset = 1'b1;
        void'($urandom(32'h79fa_b651));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            doOp(opSt, 1, 0, 1, 0, 0);
            doOp(opSt, 1, 0, 1, 0, 0);
            doOp(opLd, 0, 0, 0, 1, 4);
            doOp(opLd, 0, 0, 1, 1, 3);
            doOp(opLd, 1, 0, 1, 2, 4);
            doOp(opLd, 1, 0, 1, 2, 4);
            viewReg(4);
            doOp(opEx, 0, 1, 0, 0, 3);
            viewReg(3);
            doOp(opEx, 0, 0, 0, 0, 4);
            viewReg(4);
            doOp(opSt, 0, 0, 1, 0, 0);
            doOp(opLd, 0, 0, 1, 1, 5);
            doOp(opLd, 0, 0, 1, 2, 5);
        end
        $display("test lanes and extends done");
        doOp(opLd, 1, 0, 1, 6, 7);
        doOp(opSt, 0, 0, 1, 6, 0);
        viewReg(6);
        doOp(opLd, 0, 0, 0, 8, 9);
        doOp(opLd, 0, 0, 1, 6, 10);
        viewReg(6);
        $display("test misaligned access done");
        final_report();
    end
endmodule : testbench
